// File: rtl/aer_top.sv
`timescale 1ns/1ns
// Operation
// - Hardware, supply and calibration faults give codes A600/A601/A603; run off, error on.
// - Alarm-mode channel out of range gives A400 plus index; run off, error on.
// - Warning with flash gives A000 plus index; run stays on, error blinks.
// - Warning without flash gives A800 plus index; run on, error off.
// - Low byte enables range detection per channel; high byte selects alarm or warning.
// - Per-channel bit chooses whether a warning flashes the error indicator.
// - Flag word: bits 0-7 channel over range, bit 15 supply abnormal.
module aer_top #(
  parameter int unsigned BLINK_HALF_CYC = aer_pkg::BLINK_HALF_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        hw_fail_in,
  input  wire logic        ext_volt_bad_in,
  input  wire logic        cal_fault_in,
  input  wire logic [7:0]  ch_over_range_in,
  output logic             run_led,
  output logic             err_led,
  output logic [15:0]      err_code,
  output logic             irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [10:0] sync1;
    logic [10:0] sync2;
    logic [15:0] detect_ctrl;
    logic [7:0]  warn_led;
    logic [2:0]  irq_status;
    logic [2:0]  irq_mask;
    logic [2:0]  ev_prev;
    logic [15:0] err_code;
    logic        run_led;
    logic        err_led;
    logic        irq;
  } aer_top_st_t;

  aer_top_st_t st_r;
  aer_top_st_t st_nxt;

  aer_reg_if   rif ();

  logic        blink_phase;
  logic [7:0]  over_s;
  logic        hw_fail_s;
  logic        ext_volt_s;
  logic        cal_fault_s;
  logic [7:0]  ch_alarm;
  logic [7:0]  ch_warn_flash;
  logic [7:0]  ch_warn_steady;
  logic [15:0] ch_code [aer_pkg::NUM_CH];
  logic        mod_alarm;
  logic        any_alarm;
  logic        any_warn;
  logic [2:0]  ev_now;
  logic [2:0]  ev_rise;
  logic [15:0] conv_flags;
  logic [15:0] code_sel;
  logic [5:0]  rd_word;
  logic [5:0]  wr_word;
  logic [5:0]  ch_base_word;

  // ----------------------------------------------------------------
  // Bus slave and blink timebase
  // ----------------------------------------------------------------
  aer_axil u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .rif     (rif)
  );

  aer_blink #(
    .HALF_CYC (BLINK_HALF_CYC)
  ) u_blink (
    .aclk    (aclk),
    .aresetn (aresetn),
    .phase   (blink_phase)
  );

  // ----------------------------------------------------------------
  // Synchronised fault inputs
  // ----------------------------------------------------------------
  // Only the second stage is read; the first may be metastable
  assign over_s      = st_r.sync2[7:0];
  assign hw_fail_s   = st_r.sync2[8];
  assign ext_volt_s  = st_r.sync2[9];
  assign cal_fault_s = st_r.sync2[10];

  // ----------------------------------------------------------------
  // Per-channel classification
  // ----------------------------------------------------------------
  // Codes follow the live input, so they drop as soon as it recovers
  for (genvar i = 0; i < aer_pkg::NUM_CH; i++) begin : g_ch
    logic det;
    assign det               = st_r.detect_ctrl[i] & over_s[i];
    assign ch_alarm[i]       = det & st_r.detect_ctrl[aer_pkg::NUM_CH + i];
    assign ch_warn_flash[i]  = det & ~st_r.detect_ctrl[aer_pkg::NUM_CH + i]
                               & st_r.warn_led[i];
    assign ch_warn_steady[i] = det & ~st_r.detect_ctrl[aer_pkg::NUM_CH + i]
                               & ~st_r.warn_led[i];
    always_comb begin
      if (ch_alarm[i]) begin
        ch_code[i] = aer_pkg::CODE_CH_ALARM + 16'(i);
      end else if (ch_warn_flash[i]) begin
        ch_code[i] = aer_pkg::CODE_WARN_FLASH + 16'(i);
      end else if (ch_warn_steady[i]) begin
        ch_code[i] = aer_pkg::CODE_WARN_STEADY + 16'(i);
      end else begin
        ch_code[i] = aer_pkg::CODE_NONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Severity summary
  // ----------------------------------------------------------------
  assign mod_alarm  = hw_fail_s | ext_volt_s | cal_fault_s;
  assign any_alarm  = mod_alarm | (|ch_alarm);
  assign any_warn   = (|ch_warn_flash) | (|ch_warn_steady);
  assign conv_flags = {ext_volt_s, 7'h00, over_s};
  assign ev_now     = {any_warn, |ch_alarm, mod_alarm};
  assign ev_rise    = ev_now & ~st_r.ev_prev;

  // Worst condition wins; lowest channel wins within one class
  always_comb begin
    code_sel = aer_pkg::CODE_NONE;
    for (int k = aer_pkg::NUM_CH - 1; k >= 0; k--) begin
      if (ch_warn_steady[k]) begin
        code_sel = ch_code[k];
      end
    end
    for (int k = aer_pkg::NUM_CH - 1; k >= 0; k--) begin
      if (ch_warn_flash[k]) begin
        code_sel = ch_code[k];
      end
    end
    for (int k = aer_pkg::NUM_CH - 1; k >= 0; k--) begin
      if (ch_alarm[k]) begin
        code_sel = ch_code[k];
      end
    end
    if (cal_fault_s) begin
      code_sel = aer_pkg::CODE_CAL_FAULT;
    end
    if (ext_volt_s) begin
      code_sel = aer_pkg::CODE_EXT_VOLT;
    end
    if (hw_fail_s) begin
      code_sel = aer_pkg::CODE_HW_FAIL;
    end
  end

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  assign rd_word      = rif.rd_addr[7:2];
  assign wr_word      = rif.wr_addr[7:2];
  assign ch_base_word = aer_pkg::OFS_CH_CODE[7:2];

  // Read mux; unmapped words read zero with an error response
  always_comb begin
    rif.rd_data = 32'h0000_0000;
    rif.rd_ok   = 1'b1;
    if (rd_word >= ch_base_word && rd_word < ch_base_word + 6'(aer_pkg::NUM_CH)) begin
      rif.rd_data = {16'h0000, ch_code[3'(rd_word - ch_base_word)]};
    end else begin
      unique case (rd_word)
        aer_pkg::OFS_DETECT_CTRL[7:2]: rif.rd_data = {16'h0000, st_r.detect_ctrl};
        aer_pkg::OFS_WARN_LED[7:2]:    rif.rd_data = {24'h000000, st_r.warn_led};
        aer_pkg::OFS_CONV_FLAGS[7:2]:  rif.rd_data = {16'h0000, conv_flags};
        aer_pkg::OFS_ERR_CODE[7:2]:    rif.rd_data = {16'h0000, st_r.err_code};
        aer_pkg::OFS_IRQ_STATUS[7:2]:  rif.rd_data = {29'h00000000, st_r.irq_status};
        aer_pkg::OFS_IRQ_MASK[7:2]:    rif.rd_data = {29'h00000000, st_r.irq_mask};
        aer_pkg::OFS_MOD_STATUS[7:2]:  rif.rd_data = {27'h0000000, st_r.err_led,
                                                      st_r.run_led, cal_fault_s,
                                                      ext_volt_s, hw_fail_s};
        default:                       rif.rd_ok = 1'b0;
      endcase
    end
  end

  // Only the four writable words accept a write
  assign rif.wr_ok = (wr_word == aer_pkg::OFS_DETECT_CTRL[7:2])
                   | (wr_word == aer_pkg::OFS_WARN_LED[7:2])
                   | (wr_word == aer_pkg::OFS_IRQ_STATUS[7:2])
                   | (wr_word == aer_pkg::OFS_IRQ_MASK[7:2]);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt       = st_r;
    st_nxt.sync1 = {cal_fault_in, ext_volt_bad_in, hw_fail_in, ch_over_range_in};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.ev_prev = ev_now;

    // Software writes, honouring byte lanes
    if (rif.wr_en) begin
      unique case (wr_word)
        aer_pkg::OFS_DETECT_CTRL[7:2]: begin
          if (rif.wr_strb[0]) begin
            st_nxt.detect_ctrl[7:0] = rif.wr_data[7:0];
          end
          if (rif.wr_strb[1]) begin
            st_nxt.detect_ctrl[15:8] = rif.wr_data[15:8];
          end
        end
        aer_pkg::OFS_WARN_LED[7:2]: begin
          if (rif.wr_strb[0]) begin
            st_nxt.warn_led = rif.wr_data[7:0];
          end
        end
        aer_pkg::OFS_IRQ_MASK[7:2]: begin
          if (rif.wr_strb[0]) begin
            st_nxt.irq_mask = rif.wr_data[2:0];
          end
        end
        aer_pkg::OFS_IRQ_STATUS[7:2]: begin
          if (rif.wr_strb[0]) begin
            st_nxt.irq_status = st_r.irq_status & ~rif.wr_data[2:0];
          end
        end
        default: ;
      endcase
    end

    // New events set after the clear, so a simultaneous event survives
    st_nxt.irq_status = st_nxt.irq_status | ev_rise;
    st_nxt.irq        = |(st_nxt.irq_status & st_nxt.irq_mask);

    // Indicators: alarms outrank warnings, flashing outranks steady
    st_nxt.err_code = code_sel;
    st_nxt.run_led  = ~any_alarm;
    if (any_alarm) begin
      st_nxt.err_led = 1'b1;
    end else if (|ch_warn_flash) begin
      st_nxt.err_led = blink_phase;
    end else begin
      st_nxt.err_led = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r             <= '0;
      st_r.detect_ctrl <= aer_pkg::DETECT_CTRL_RST;
      st_r.warn_led    <= aer_pkg::WARN_LED_RST;
      st_r.irq_mask    <= aer_pkg::IRQ_MASK_RST;
      st_r.err_code    <= aer_pkg::CODE_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign run_led  = st_r.run_led;
  assign err_led  = st_r.err_led;
  assign err_code = st_r.err_code;
  assign irq      = st_r.irq;

endmodule

// File: rtl/aer_pkg.sv
package aer_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam int unsigned BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned NUM_EV = 3;
  localparam int unsigned SYNC_W = 11;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_DETECT_CTRL = 8'h00;
  localparam logic [7:0] OFS_WARN_LED    = 8'h04;
  localparam logic [7:0] OFS_CONV_FLAGS  = 8'h08;
  localparam logic [7:0] OFS_ERR_CODE    = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h14;
  localparam logic [7:0] OFS_MOD_STATUS  = 8'h18;
  localparam logic [7:0] OFS_CH_CODE     = 8'h20;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned FLAG_EXT_VOLT_BIT = 15;
  localparam int unsigned EV_MOD_ALARM      = 0;
  localparam int unsigned EV_CH_ALARM       = 1;
  localparam int unsigned EV_CH_WARN        = 2;
  localparam logic [15:0] DETECT_CTRL_RST   = 16'h0000;
  localparam logic [7:0]  WARN_LED_RST      = 8'h00;
  localparam logic [2:0]  IRQ_MASK_RST      = 3'h0;

  // ----------------------------------------------------------------
  // Error codes
  // ----------------------------------------------------------------
  localparam logic [15:0] CODE_NONE        = 16'h0000;
  localparam logic [15:0] CODE_HW_FAIL     = 16'hA600;
  localparam logic [15:0] CODE_EXT_VOLT    = 16'hA601;
  localparam logic [15:0] CODE_CAL_FAULT   = 16'hA603;
  localparam logic [15:0] CODE_CH_ALARM    = 16'hA400;
  localparam logic [15:0] CODE_WARN_FLASH  = 16'hA000;
  localparam logic [15:0] CODE_WARN_STEADY = 16'hA800;

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: rtl/aer_reg_if.sv
`timescale 1ns/1ns
interface aer_reg_if;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;

  modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input wr_ok, rd_data, rd_ok);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output wr_ok, rd_data, rd_ok);
endinterface

// File: rtl/aer_blink.sv
`timescale 1ns/1ns
module aer_blink #(
  parameter int unsigned HALF_CYC = aer_pkg::BLINK_HALF_CYC
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  output logic      phase
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        phase;
  } aer_blink_st_t;

  aer_blink_st_t st_r;
  aer_blink_st_t st_nxt;

  // Free-running half-period counter; phase toggles at each wrap
  always_comb begin
    st_nxt = st_r;
    if (st_r.cnt >= 32'(HALF_CYC - 1)) begin
      st_nxt.cnt   = 32'h0000_0000;
      st_nxt.phase = ~st_r.phase;
    end else begin
      st_nxt.cnt = st_r.cnt + 32'h0000_0001;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign phase = st_r.phase;

endmodule

// File: rtl/aer_axil.sv
`timescale 1ns/1ns
module aer_axil (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  aer_reg_if.bus           rif
);

  typedef struct packed {
    logic        aw_got;
    logic        w_got;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        ar_got;
    logic [7:0]  raddr;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } aer_axil_st_t;

  aer_axil_st_t st_r;
  aer_axil_st_t st_nxt;
  logic         wr_fire;
  logic         rd_fire;

  // Commit once both halves are held and no response is pending
  assign wr_fire = st_r.aw_got & st_r.w_got & ~st_r.bvalid;
  assign rd_fire = st_r.ar_got & ~st_r.rvalid;

  // Channel handshakes; address and data may arrive in either order
  always_comb begin
    st_nxt = st_r;
    if (awvalid && st_r.awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.waddr  = awaddr;
    end
    if (wvalid && st_r.wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = wdata;
      st_nxt.wstrb = wstrb;
    end
    if (wr_fire) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = rif.wr_ok ? aer_pkg::RESP_OKAY : aer_pkg::RESP_SLVERR;
    end
    if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (arvalid && st_r.arready) begin
      st_nxt.ar_got = 1'b1;
      st_nxt.raddr  = araddr;
    end
    if (rd_fire) begin
      st_nxt.ar_got = 1'b0;
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rif.rd_data;
      st_nxt.rresp  = rif.rd_ok ? aer_pkg::RESP_OKAY : aer_pkg::RESP_SLVERR;
    end
    if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end
    // Ready only when the slot is free, so one transfer per direction
    st_nxt.awready = ~st_nxt.aw_got & ~st_nxt.bvalid;
    st_nxt.wready  = ~st_nxt.w_got & ~st_nxt.bvalid;
    st_nxt.arready = ~st_nxt.ar_got & ~st_nxt.rvalid;
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs and register-side strobes
  assign awready     = st_r.awready;
  assign wready      = st_r.wready;
  assign bvalid      = st_r.bvalid;
  assign bresp       = st_r.bresp;
  assign arready     = st_r.arready;
  assign rvalid      = st_r.rvalid;
  assign rdata       = st_r.rdata;
  assign rresp       = st_r.rresp;
  assign rif.wr_en   = wr_fire;
  assign rif.wr_addr = st_r.waddr;
  assign rif.wr_data = st_r.wdata;
  assign rif.wr_strb = st_r.wstrb;
  assign rif.rd_addr = st_r.raddr;

endmodule

// File: sim/aer_monitor.sv
`timescale 1ns/1ns
module aer_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        hw_fail_in,
  input wire logic        ext_volt_bad_in,
  input wire logic        cal_fault_in,
  input wire logic [7:0]  ch_over_range_in,
  input wire logic        run_led,
  input wire logic        err_led,
  input wire logic [15:0] err_code
);
  // ------------------
  // Pin history
  // ------------------
  logic [10:0] h1_r;
  logic [10:0] h2_r;
  logic [10:0] h3_r;
  logic [2:0]  rc_r;
  logic        rdy;

  // Outputs lag the pins by two sync stages plus the output stage
  always_ff @(posedge aclk) begin
    h1_r <= {hw_fail_in, ext_volt_bad_in, cal_fault_in, ch_over_range_in};
    h2_r <= h1_r;
    h3_r <= h2_r;
    if (!aresetn) begin
      rc_r <= 3'h0;
    end else if (rc_r != 3'h4) begin
      rc_r <= rc_r + 3'h1;
    end
  end
  // History is trusted only once it no longer reaches back into reset
  assign rdy = (rc_r == 3'h4);

  // ------------------
  // Properties
  // ------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_hw_code: assert property (rdy && h3_r[10] |->
    err_code == 16'hA600 && !run_led && err_led) else $error("hw fault code wrong");
  a_volt_code: assert property (rdy && h3_r[10:9] == 2'h1 |->
    err_code == 16'hA601) else $error("supply fault code wrong");
  a_cal_code: assert property (rdy && h3_r[10:8] == 3'h1 |->
    err_code == 16'hA603) else $error("calibration fault code wrong");
  a_alarm_leds: assert property (err_code[15:8] inside {8'hA4, 8'hA6} |->
    !run_led && err_led) else $error("alarm indicators wrong");
  a_flash_run: assert property (err_code[15:8] == 8'hA0 |-> run_led)
    else $error("flashing warning stopped run indicator");
  a_steady_leds: assert property (err_code[15:8] == 8'hA8 |->
    run_led && !err_led) else $error("steady warning indicators wrong");
  a_code_cause: assert property (rdy && err_code[15:8] inside {8'hA4, 8'hA0, 8'hA8} |->
    err_code[7:3] == 5'h00 && h3_r[err_code[2:0]]) else $error("channel code without cause");
  a_quiet_clear: assert property (rdy && h3_r == 11'h000 |->
    err_code == 16'h0000 && run_led && !err_led) else $error("code left after clear");

  c_hw: cover property (err_code == 16'hA600);
  c_blink: cover property (err_code[15:8] == 8'hA0 && $changed(err_led));
  c_steady: cover property (err_code[15:8] == 8'hA8);
endmodule

bind aer_top aer_monitor mon (.*);

// File: sim/aer_cpu_model.sv
`timescale 1ns/1ns
module aer_cpu_model (
  input  wire logic        aclk,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // Idle bus; the controller always writes whole words
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr} = 16'h0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
  end

  // Write; dly holds off bready to play a slow controller
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input int dly,
                    output logic [1:0] r, output bit to);
    int n;
    bit done;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (dly == 0);
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      r = s_axi_bresp;
      // One ready update per edge; dropped right after the handshake
      done = s_axi_bready && s_axi_bvalid;
      s_axi_bready <= !done && (n >= dly);
    end while (!done && n < 200);
    to = !done;
  endtask

  // Read; same hold-off on rready
  task automatic rd(input logic [7:0] a, input int dly, output logic [31:0] d,
                    output logic [1:0] r, output bit to);
    int n;
    bit done;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (dly == 0);
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      done = s_axi_rready && s_axi_rvalid;
      s_axi_rready <= !done && (n >= dly);
    end while (!done && n < 200);
    to = !done;
  endtask
endmodule

// File: sim/tb.sv
`timescale 1ns/1ns
module tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, ch_over_range_in, ch, wled;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        hw_fail_in, ext_volt_bad_in, cal_fault_in, run_led, err_led, irq, b;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] err_code, det, pc;
  logic [17:0] ev;
  logic [2:0]  flt, ci;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          seed = 32'hc85f23aa;

  // Short blink period keeps the flashing check cheap
  aer_top #(.BLINK_HALF_CYC(4)) dut (.*);
  aer_cpu_model p (.*);

  // 50 MHz clock
  always #10 aclk = ~aclk;

  // Lowest set bit wins among channels of one class
  function automatic logic [2:0] lo(input logic [7:0] x);
    lo = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (x[i]) lo = i[2:0];
    end
  endfunction

  // Expected {alarm, flash, code} for faults, channels and setup
  function automatic logic [17:0] expv(input logic [2:0] f, input logic [7:0] c,
                                       input logic [15:0] d, input logic [7:0] w);
    logic [7:0] a, fl, st;
    a = c & d[7:0] & d[15:8];
    fl = c & d[7:0] & ~d[15:8] & w;
    st = c & d[7:0] & ~d[15:8] & ~w;
    if (f[2]) return {2'h2, 16'hA600};
    if (f[1]) return {2'h2, 16'hA601};
    if (f[0]) return {2'h2, 16'hA603};
    if (|a) return {2'h2, 16'hA400 + lo(a)};
    if (|fl) return {2'h1, 16'hA000 + lo(fl)};
    if (|st) return {2'h0, 16'hA800 + lo(st)};
    return 18'h00000;
  endfunction

  task automatic finish_test();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Bus accesses with random ready hold-off; a hung bus ends the run
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    bit         to;
    p.wr(a, d, $random(seed) & 3, r, to);
    if (to) begin
      miscompares++;
      finish_test();
    end else begin
      chk(r, er, "bresp");
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    bit          to;
    p.rd(a, $random(seed) & 3, d, r, to);
    if (to) begin
      miscompares++;
      finish_test();
    end else begin
      chk(d, e, "rdata");
      chk(r, er, "rresp");
    end
  endtask

  initial begin
    {hw_fail_in, ext_volt_bad_in, cal_fault_in, ch_over_range_in} = 11'h000;
    repeat (6) @(posedge aclk);
    chk({err_code, run_led, err_led, irq}, 32'h0, "reset outputs");
    aresetn <= 1'b1;
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h04, 32'h0, 2'h0);
    rd(8'h1C, 32'h0, 2'h2);
    wr(8'h08, 32'h1, 2'h2);
    // Random setups; first passes force each module fault and an all-alarm case
    for (int k = 0; k < 40; k++) begin
      det = (k == 3) ? 16'hFFFF : 16'($random(seed));
      wled = 8'($random(seed));
      ch = (k == 3) ? 8'hFF : 8'($random(seed));
      flt = (k < 3) ? (3'h4 >> k) : 3'h0;
      if (k > 3 && k % 4 == 0) flt = 3'($random(seed));
      wr(8'h00, {16'h0, det}, 2'h0);
      wr(8'h04, {24'h0, wled}, 2'h0);
      {hw_fail_in, ext_volt_bad_in, cal_fault_in, ch_over_range_in} <= {flt, ch};
      repeat (5) @(posedge aclk);
      ev = expv(flt, ch, det, wled);
      chk(err_code, ev[15:0], "code");
      chk(run_led, !ev[17], "run indicator");
      b = err_led;
      repeat (4) @(posedge aclk);
      chk(err_led, ev[16] ? !b : ev[17], "error indicator");
      rd(8'h0C, {16'h0, ev[15:0]}, 2'h0);
      rd(8'h08, {16'h0, flt[1], 7'h0, ch}, 2'h0);
      ci = lo(ch);
      pc = !(ch[ci] && det[ci]) ? 16'h0 : det[8 + ci] ? 16'hA400 + ci :
           wled[ci] ? 16'hA000 + ci : 16'hA800 + ci;
      rd(8'h20 + {ci, 2'h0}, {16'h0, pc}, 2'h0);
    end
    // Interrupt: raise, clear while still alarmed, then mask a live status
    {hw_fail_in, ext_volt_bad_in, cal_fault_in, ch_over_range_in} <= 11'h000;
    wr(8'h00, 32'h0101, 2'h0);
    repeat (5) @(posedge aclk);
    wr(8'h10, 32'h7, 2'h0);
    wr(8'h14, 32'h7, 2'h0);
    chk(irq, 1'b0, "irq idle");
    ch_over_range_in <= 8'h01;
    repeat (5) @(posedge aclk);
    chk(irq, 1'b1, "irq raised");
    rd(8'h10, 32'h2, 2'h0);
    wr(8'h10, 32'h2, 2'h0);
    chk(irq, 1'b0, "irq cleared");
    hw_fail_in <= 1'b1;
    repeat (5) @(posedge aclk);
    chk(irq, 1'b1, "irq fault");
    rd(8'h18, 32'h11, 2'h0);
    wr(8'h14, 32'h0, 2'h0);
    chk(irq, 1'b0, "irq masked");
    rd(8'h10, 32'h1, 2'h0);
    finish_test();
  end
endmodule
